/* rsf_params.svh */
// timing, offset and field constants of the slave frame timing block
// assumes a 20 MHz system clock and a 1 ms idle sampling tick
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH
// clock and tick
`define RSF_CLK_PERIOD_NS    50
`define RSF_TICK_NS          1000000
`define RSF_TURNAROUND_TICKS 8'h01
// idle gaps in ticks: end of frame and broken frame, per baud class
`define RSF_END_4800         8'h08
`define RSF_BRK_4800         8'h04
`define RSF_END_9600         8'h04
`define RSF_BRK_9600         8'h02
`define RSF_END_19200        8'h02
`define RSF_BRK_19200        8'h01
`define RSF_END_HIGH         8'h01
`define RSF_BRK_HIGH         8'h01
// frame screening and reply forming
`define RSF_MIN_LEN          6'h03
`define RSF_EXC_LEN          6'h05
`define RSF_BCAST_ADDR       8'h00
`define RSF_EXC_FLAG         8'h80
`define RSF_CRC_INIT         16'hFFFF
`define RSF_CRC_POLY         16'hA001
`define RSF_CRC_GOOD         16'h0000
// register offsets
`define RSF_REG_CFG          8'h00
`define RSF_REG_DELAY        8'h04
`define RSF_REG_TIMEOUT      8'h08
`define RSF_REG_STATUS       8'h0C
`define RSF_REG_VERDICT      8'h10
`define RSF_REG_FRAME        8'h40
// reset values
`define RSF_CFG_RST          16'h0101
`define RSF_DELAY_RST        16'h0000
`define RSF_TIMEOUT_RST      16'h0000
// fields
`define RSF_BAUD_MSB         1
`define RSF_BAUD_LSB         0
`define RSF_ADDR_MSB         15
`define RSF_ADDR_LSB         8
`define RSF_ST_PEND          0
`define RSF_ST_BCAST         1
`define RSF_ST_TOUT          2
`define RSF_ST_BROKEN        3
`define RSF_VD_OK            0
`endif

/* rsf_pkg.sv */
// types of the slave frame timing block
// rsf_params.svh holds the other constants; the enum encodings stand here
package rsf_pkg;
    // main sequence, gray coded along rx, verdict, delay, send
    typedef enum logic [1:0] {
        RSF_RX      = 2'h0,
        RSF_VERDICT = 2'h1,
        RSF_DELAY   = 2'h3,
        RSF_SEND    = 2'h2
    } rsf_state_type;
    // baud class selected in the configuration register
    typedef enum logic [1:0] {
        RSF_B4800  = 2'h0,
        RSF_B9600  = 2'h1,
        RSF_B19200 = 2'h2,
        RSF_BHIGH  = 2'h3
    } rsf_baud_type;
endpackage : rsf_pkg

/* rsf_frame_timing.sv */
// slave side frame delimiting, screening, reply timing and link timeout
// assumes a byte receiver and transmitter on sys_clk and a host on the register port
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "rsf_params.svh"

module rsf_frame_timing
    import rsf_pkg::*;
#(
    parameter int TICK_CYCLES = `RSF_TICK_NS / `RSF_CLK_PERIOD_NS,
    parameter int DEPTH       = 32
) (
    // clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clkEn,
    // register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    // received characters
    input  wire logic [7:0]  rxByte,
    input  wire logic        rxStrobe,
    input  wire logic        rxError,
    // reply characters
    output logic      [7:0]  txByte,
    output logic             txValid,
    input  wire logic        txReady,
    output logic             txEnable,
    // status levels
    output logic             framePending,
    output logic             linkTimeout
);

    // ************************************************************
    // helpers
    // ************************************************************

    // end of frame gap in ticks for a baud class
    function automatic logic [7:0] endGap(input logic [1:0] sel);
        case (sel)
            RSF_B4800:  endGap = `RSF_END_4800;
            RSF_B9600:  endGap = `RSF_END_9600;
            RSF_B19200: endGap = `RSF_END_19200;
            default:    endGap = `RSF_END_HIGH;
        endcase
    endfunction : endGap

    // broken frame gap in ticks for a baud class
    function automatic logic [7:0] brkGap(input logic [1:0] sel);
        case (sel)
            RSF_B4800:  brkGap = `RSF_BRK_4800;
            RSF_B9600:  brkGap = `RSF_BRK_9600;
            RSF_B19200: brkGap = `RSF_BRK_19200;
            default:    brkGap = `RSF_BRK_HIGH;
        endcase
    endfunction : brkGap

    // one byte of the reflected checksum
    function automatic logic [15:0] crcStep(input logic [15:0] c, input logic [7:0] b);
        logic [15:0] r;
        r = c ^ {8'h00, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `RSF_CRC_POLY) : (r >> 1);
        end
        crcStep = r;
    endfunction : crcStep

    // ************************************************************
    // reset release
    // ************************************************************

    logic rstMeta;
    logic rstSyncN;

    // asynchronous assert, two flop release
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstMeta  <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta  <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // ************************************************************
    // millisecond tick
    // ************************************************************

    rsf_state_type state;
    logic [31:0] tickCnt;
    logic [31:0] next_tickCnt;
    logic        tick;
    logic        next_tick;

    // millisecond pulse, restarted by each taken character
    always_comb begin
        next_tick    = 1'b0;
        next_tickCnt = tickCnt + 32'h0000_0001;
        if (state == RSF_RX && rxStrobe) begin
            next_tickCnt = 32'h0000_0000;
        end else if (tickCnt >= 32'(TICK_CYCLES - 1)) begin
            next_tickCnt = 32'h0000_0000;
            next_tick    = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            tickCnt <= 32'h0000_0000;
            tick    <= 1'b0;
        end else if (clkEn) begin
            tickCnt <= next_tickCnt;
            tick    <= next_tick;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************

    logic [15:0] cfg;
    logic [15:0] replyDelaySetting;
    logic [15:0] linkTimeoutSetting;
    logic [15:0] next_cfg;
    logic [15:0] next_replyDelaySetting;
    logic [15:0] next_linkTimeoutSetting;
    logic [15:0] next_regRdata;
    logic        brokenSeen;
    logic        next_brokenSeen;
    logic        dropBroken;
    logic        verdictWr;
    logic [7:0]  buffer [DEPTH];
    logic [5:0]  rxCount;
    logic        bcast;
    logic [1:0]  baud;
    logic [7:0]  station;
    logic [7:0]  frameIdx;

    assign baud      = cfg[`RSF_BAUD_MSB:`RSF_BAUD_LSB];
    assign station   = cfg[`RSF_ADDR_MSB:`RSF_ADDR_LSB];
    assign verdictWr = regWr && (regAddr == `RSF_REG_VERDICT) && (state == RSF_VERDICT);
    assign frameIdx  = (regAddr - `RSF_REG_FRAME) >> 2;

    // writes, read mux and the sticky broken flag
    always_comb begin
        next_cfg                = cfg;
        next_replyDelaySetting  = replyDelaySetting;
        next_linkTimeoutSetting = linkTimeoutSetting;
        next_brokenSeen         = brokenSeen;
        next_regRdata           = 16'h0000;
        if (regWr) begin
            case (regAddr)
                `RSF_REG_CFG:     next_cfg = regWdata;
                `RSF_REG_DELAY:   next_replyDelaySetting = regWdata;
                `RSF_REG_TIMEOUT: next_linkTimeoutSetting = regWdata;
                `RSF_REG_STATUS:  begin
                    if (regWdata[`RSF_ST_BROKEN]) begin
                        next_brokenSeen = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (dropBroken) begin
            next_brokenSeen = 1'b1; // set wins over clear
        end
        if (regRd) begin
            case (regAddr)
                `RSF_REG_CFG:     next_regRdata = cfg;
                `RSF_REG_DELAY:   next_regRdata = replyDelaySetting;
                `RSF_REG_TIMEOUT: next_regRdata = linkTimeoutSetting;
                `RSF_REG_STATUS:  begin
                    next_regRdata[`RSF_ST_PEND]   = (state == RSF_VERDICT);
                    next_regRdata[`RSF_ST_BCAST]  = bcast;
                    next_regRdata[`RSF_ST_TOUT]   = linkTimeout;
                    next_regRdata[`RSF_ST_BROKEN] = brokenSeen;
                    next_regRdata[15:8]           = {2'h0, rxCount};
                end
                default: begin
                    if (regAddr >= `RSF_REG_FRAME && frameIdx < 8'(DEPTH)) begin
                        next_regRdata = {8'h00, buffer[frameIdx[4:0]]};
                    end
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            cfg                <= `RSF_CFG_RST;
            replyDelaySetting  <= `RSF_DELAY_RST;
            linkTimeoutSetting <= `RSF_TIMEOUT_RST;
            brokenSeen         <= 1'b0;
            regRdata           <= 16'h0000;
        end else if (clkEn) begin
            cfg                <= next_cfg;
            replyDelaySetting  <= next_replyDelaySetting;
            linkTimeoutSetting <= next_linkTimeoutSetting;
            brokenSeen         <= next_brokenSeen;
            regRdata           <= next_regRdata;
        end
    end

    // ************************************************************
    // frame reception, screening and reply
    // ************************************************************

    rsf_state_type next_state;
    logic [5:0]  next_rxCount;
    logic [7:0]  idle;
    logic [7:0]  next_idle;
    logic        broken;
    logic        next_broken;
    logic [15:0] crc;
    logic [15:0] next_crc;
    logic        next_bcast;
    logic [15:0] delayCnt;
    logic [15:0] next_delayCnt;
    logic [15:0] needDelay;
    logic        isExc;
    logic        next_isExc;
    logic [7:0]  excCode;
    logic [7:0]  next_excCode;
    logic [5:0]  txIdx;
    logic [5:0]  next_txIdx;
    logic [5:0]  txLen;
    logic [7:0]  next_txByte;
    logic        next_txValid;
    logic        next_txEnable;
    logic        validPulse;
    logic        legal;
    logic        bufWr;

    // minimum reply delay is the end gap plus the turnaround wait
    always_comb begin
        needDelay = {8'h00, endGap(baud)} + {8'h00, `RSF_TURNAROUND_TICKS};
        if (replyDelaySetting > needDelay) begin
            needDelay = replyDelaySetting;
        end
    end

    assign legal = ((buffer[0] == station) || (buffer[0] == `RSF_BCAST_ADDR))
                   && (rxCount >= `RSF_MIN_LEN);
    assign txLen = isExc ? `RSF_EXC_LEN : rxCount;
    assign bufWr = (state == RSF_RX) && rxStrobe && (rxCount < 6'(DEPTH));

    // sequence of receive, wait for the verdict, delay and send
    always_comb begin
        next_state    = state;
        next_rxCount  = rxCount;
        next_idle     = idle;
        next_broken   = broken;
        next_crc      = crc;
        next_bcast    = bcast;
        next_delayCnt = delayCnt;
        next_isExc    = isExc;
        next_excCode  = excCode;
        next_txIdx    = txIdx;
        next_txByte   = txByte;
        next_txValid  = txValid;
        next_txEnable = txEnable;
        validPulse    = 1'b0;
        dropBroken    = 1'b0;
        if (tick && delayCnt != 16'hFFFF) begin
            next_delayCnt = delayCnt + 16'h0001;
        end
        case (state)
            RSF_RX: begin
                if (rxStrobe) begin
                    next_idle = 8'h00;
                    next_crc  = crcStep(crc, rxByte);
                    if (rxCount < 6'(DEPTH)) begin
                        next_rxCount = rxCount + 6'h01;
                    end else begin
                        next_broken = 1'b1; // overflow
                    end
                    if (rxError || idle >= brkGap(baud)) begin
                        next_broken = 1'b1;
                    end
                end else if (tick && rxCount != 6'h00) begin
                    if (idle != 8'hFF) begin
                        next_idle = idle + 8'h01;
                    end
                    if (idle + 8'h01 >= endGap(baud)) begin
                        // gap long enough to close the frame
                        next_rxCount  = 6'h00;
                        next_idle     = 8'h00;
                        next_broken   = 1'b0;
                        next_crc      = `RSF_CRC_INIT;
                        next_delayCnt = 16'h0000;
                        if (broken) begin
                            dropBroken = 1'b1;
                        end else if (legal && crc == `RSF_CRC_GOOD) begin
                            validPulse   = 1'b1;
                            next_rxCount = rxCount;
                            next_bcast   = (buffer[0] == `RSF_BCAST_ADDR);
                            next_state   = RSF_VERDICT;
                        end
                    end
                end
            end
            RSF_VERDICT: begin
                // host decides whether the request was correct
                if (verdictWr) begin
                    next_isExc   = !regWdata[`RSF_VD_OK];
                    next_excCode = regWdata[15:8];
                    next_crc     = `RSF_CRC_INIT;
                    next_txIdx   = 6'h00;
                    if (bcast) begin
                        next_state   = RSF_RX;
                        next_rxCount = 6'h00;
                    end else begin
                        next_state = RSF_DELAY;
                    end
                end
            end
            RSF_DELAY: begin
                if (delayCnt >= needDelay) begin
                    next_state    = RSF_SEND;
                    next_txEnable = 1'b1;
                end
            end
            RSF_SEND: begin
                if (!txValid) begin
                    next_txValid = 1'b1;
                    if (!isExc) begin
                        next_txByte = buffer[txIdx[4:0]];
                    end else begin
                        case (txIdx)
                            6'h00: next_txByte = buffer[0];
                            6'h01: next_txByte = buffer[1] | `RSF_EXC_FLAG;
                            6'h02: next_txByte = excCode;
                            6'h03: next_txByte = crc[7:0];
                            default: next_txByte = crc[15:8];
                        endcase
                        if (txIdx < 6'h03) begin
                            next_crc = crcStep(crc, next_txByte);
                        end
                    end
                end else if (txReady) begin
                    next_txValid = 1'b0;
                    next_txIdx   = txIdx + 6'h01;
                    if (txIdx + 6'h01 >= txLen) begin
                        next_state    = RSF_RX;
                        next_txEnable = 1'b0;
                        next_rxCount  = 6'h00;
                        next_crc      = `RSF_CRC_INIT;
                        next_idle     = 8'h00;
                    end
                end
            end
            default: next_state = RSF_RX;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            state        <= RSF_RX;
            rxCount      <= 6'h00;
            idle         <= 8'h00;
            broken       <= 1'b0;
            crc          <= `RSF_CRC_INIT;
            bcast        <= 1'b0;
            delayCnt     <= 16'h0000;
            isExc        <= 1'b0;
            excCode      <= 8'h00;
            txIdx        <= 6'h00;
            txByte       <= 8'h00;
            txValid      <= 1'b0;
            txEnable     <= 1'b0;
            framePending <= 1'b0;
        end else if (clkEn) begin
            state        <= next_state;
            rxCount      <= next_rxCount;
            idle         <= next_idle;
            broken       <= next_broken;
            crc          <= next_crc;
            bcast        <= next_bcast;
            delayCnt     <= next_delayCnt;
            isExc        <= next_isExc;
            excCode      <= next_excCode;
            txIdx        <= next_txIdx;
            txByte       <= next_txByte;
            txValid      <= next_txValid;
            txEnable     <= next_txEnable;
            framePending <= (next_state == RSF_VERDICT);
        end
    end

    // frame store, written only while receiving
    always_ff @(posedge sys_clk) begin
        if (clkEn && bufWr) begin
            buffer[rxCount[4:0]] <= rxByte;
        end
    end

    // ************************************************************
    // link timeout
    // ************************************************************

    logic [15:0] toCnt;
    logic [15:0] next_toCnt;
    logic        next_linkTimeout;

    // milliseconds since the last valid request
    always_comb begin
        next_toCnt = toCnt;
        if (validPulse) begin
            next_toCnt = 16'h0000;
        end else if (tick && toCnt != 16'hFFFF) begin
            next_toCnt = toCnt + 16'h0001;
        end
        next_linkTimeout = (linkTimeoutSetting != 16'h0000)
                           && (next_toCnt > linkTimeoutSetting);
    end

    always_ff @(posedge sys_clk or negedge rstSyncN) begin
        if (!rstSyncN) begin
            toCnt       <= 16'h0000;
            linkTimeout <= 1'b0;
        end else if (clkEn) begin
            toCnt       <= next_toCnt;
            linkTimeout <= next_linkTimeout;
        end
    end

endmodule : rsf_frame_timing

/* rsf_frame_timing_checker.sv */
// assertions on the ports of the slave frame timing block
// assumes binding into rsf_frame_timing, one clock domain
`timescale 1ns/10ps
`include "rsf_params.svh"

module rsf_frame_timing_checker #(
    parameter int TICK_CYCLES = 20
) (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rstn,
    // register port
    input wire logic [7:0]  regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    // link side
    input wire logic        rxStrobe,
    input wire logic [7:0]  txByte,
    input wire logic        txValid,
    input wire logic        txReady,
    input wire logic        txEnable,
    input wire logic        framePending,
    input wire logic        linkTimeout
);
    localparam int T = TICK_CYCLES;
    logic [15:0] idleCnt;
    logic [15:0] toutSet;
    logic [1:0]  baud;
    int          endGap;
    // **********
    // helper state
    // **********
    // idle cycles since the last character, copies of baud class and timeout
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            idleCnt <= 16'h0000;
            toutSet <= `RSF_TIMEOUT_RST;
            baud    <= 2'h1;
        end else begin
            idleCnt <= rxStrobe ? 16'h0000 : idleCnt + {15'h0000, idleCnt != 16'hFFFF};
            if (regWr && regAddr == `RSF_REG_CFG) baud <= regWdata[1:0];
            if (regWr && regAddr == `RSF_REG_TIMEOUT) toutSet <= regWdata;
        end
    end
    // end gap in ticks for the current baud class
    always_comb begin
        case (baud)
            2'h0: endGap = `RSF_END_4800;
            2'h1: endGap = `RSF_END_9600;
            2'h2: endGap = `RSF_END_19200;
            default: endGap = `RSF_END_HIGH;
        endcase
    end
    // **********
    // assertions
    // **********
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence s_stall; txValid && !txReady; endsequence
    sequence s_accept; txValid && txReady; endsequence
    a_end_gap: assert property ($rose(framePending) |-> idleCnt >= (endGap - 1) * T)
        else $error("frame closed before the idle gap");
    a_reply_delay: assert property ($rose(txEnable) |-> idleCnt >= (2 * endGap - 1) * T)
        else $error("reply driven too early");
    a_valid_next: assert property ($rose(txEnable) |=> txValid)
        else $error("first reply byte late");
    a_byte_hold: assert property (s_stall |=> txValid && $stable(txByte))
        else $error("reply byte changed while stalled");
    a_accept_drop: assert property (s_accept |=> !txValid)
        else $error("valid not dropped after acceptance");
    a_enable_cover: assert property (txValid |-> txEnable)
        else $error("byte offered with driver off");
    a_quiet_wait: assert property (framePending |-> !txEnable)
        else $error("driver on before verdict");
    a_tout_off: assert property (toutSet == 16'h0000 && $past(toutSet, 2) == 16'h0000
        |-> !linkTimeout)
        else $error("timeout raised while disabled");
endmodule : rsf_frame_timing_checker

bind rsf_frame_timing rsf_frame_timing_checker #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
    .sys_clk(sys_clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .rxStrobe(rxStrobe), .txByte(txByte), .txValid(txValid),
    .txReady(txReady), .txEnable(txEnable), .framePending(framePending),
    .linkTimeout(linkTimeout)
);

/* rsf_master_model.sv */
// master station model: sends request characters, takes reply characters
// assumes the block's clock; replies collect in got, slow stalls the reply
`timescale 1ns/10ps

module rsf_master_model (
    // clock
    input  wire logic       sys_clk,
    // request characters
    output logic      [7:0] rxByte,
    output logic            rxStrobe,
    // reply characters
    input  wire logic [7:0] txByte,
    input  wire logic       txValid,
    output logic            txReady
);
    logic [7:0] got[$];
    logic       slow = 1'b0;
    logic [1:0] stall = 2'h0;
    initial begin
        rxByte   = 8'h00;
        rxStrobe = 1'b0;
        txReady  = 1'b0;
    end
    // transmitter: ready always, or one cycle in four when slow
    always @(posedge sys_clk) begin
        stall   <= stall + 2'h1;
        txReady <= !slow || stall == 2'h3;
        if (txValid && txReady) got.push_back(txByte);
    end
    // n characters from the top of f, an idle gap after character gapAt
    task send(input logic [63:0] f, input int n, input int gapAt, input int gapLen);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rxByte   <= f[63 - 8 * i -: 8];
            rxStrobe <= 1'b1;
            @(posedge sys_clk);
            rxByte   <= ~f[63 - 8 * i -: 8]; // stale data never repeats
            rxStrobe <= 1'b0;
            if (i == gapAt) repeat (gapLen) @(posedge sys_clk);
        end
    endtask : send
endmodule : rsf_master_model

/* rsf_frame_timing_test.sv */
// self-checking bench of the slave frame timing block
// assumes the master model and the bound checker
`timescale 1ns/10ps
`include "rsf_params.svh"

module rsf_frame_timing_test;
    localparam int TICK = 20;
    logic        sys_clk = 1'b0;
    logic        rstn = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [15:0] regWdata = 16'h0000;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [15:0] regRdata, v;
    logic [7:0]  rxByte, txByte;
    logic        rxStrobe, txValid, txReady, txEnable, framePending, linkTimeout;
    int          miscompares = 0;
    int          comparisons = 0;
    int          cycles = 0;
    int          lat;
    rsf_frame_timing #(.TICK_CYCLES(TICK)) dut_u (
        .sys_clk(sys_clk), .rstn(rstn), .clkEn(1'b1), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .rxByte(rxByte), .rxStrobe(rxStrobe), .rxError(1'b0), .txByte(txByte),
        .txValid(txValid), .txReady(txReady), .txEnable(txEnable),
        .framePending(framePending), .linkTimeout(linkTimeout)
    );
    rsf_master_model mm (
        .sys_clk(sys_clk), .rxByte(rxByte), .rxStrobe(rxStrobe),
        .txByte(txByte), .txValid(txValid), .txReady(txReady)
    );
    // **********
    // clock, watchdog, helpers
    // **********
    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            finish_test();
        end
    end
    task finish_test;
        $display("comparisons %0d, miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : finish_test
    task chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regAddr  <= a;
        regWdata <= d;
        regWr    <= 1'b1;
        @(posedge sys_clk);
        regWr    <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        v = regRdata;
    endtask : rd
    function automatic logic [15:0] crc(input logic [47:0] b);
        logic [15:0] c;
        c = `RSF_CRC_INIT;
        for (int i = 0; i < 6; i++) begin
            c = c ^ {8'h00, b[47 - 8 * i -: 8]};
            repeat (8) c = c[0] ? (c >> 1) ^ `RSF_CRC_POLY : c >> 1;
        end
        return c;
    endfunction : crc
    // six bytes plus checksum, low byte first
    task req(input logic [47:0] b, input int gapAt);
        logic [15:0] c;
        c = crc(b);
        mm.got.delete();
        mm.send({b, c[7:0], c[15:8]}, 8, gapAt, 50);
    endtask : req
    // valid request: status, verdict, then the reply against r
    task frame(input logic [47:0] b, input logic [15:0] st, input logic [15:0] vd,
               input logic [63:0] r, input int rn);
        req(b, -1);
        wait (framePending === 1'b1);
        rd(`RSF_REG_STATUS);
        chk(v, st);
        wr(`RSF_REG_VERDICT, vd);
        lat = 0;
        if (rn > 0) begin
            while (txEnable !== 1'b1) begin
                @(posedge sys_clk);
                lat++;
            end
            wait (txEnable === 1'b0);
        end
        repeat (40 * TICK) @(posedge sys_clk);
        for (int i = 0; i < rn; i++) chk({8'h00, mm.got[i]}, {8'h00, r[8 * rn - 1 - 8 * i -: 8]});
        chk(16'(mm.got.size()), 16'(rn));
    endtask : frame
    // request that must be dropped with no reply
    task drop(input logic [47:0] b, input int gapAt);
        req(b, gapAt);
        repeat (20 * TICK) @(posedge sys_clk);
        chk({15'h0000, framePending}, 16'h0000);
        chk(16'(mm.got.size()), 16'h0000);
    endtask : drop
    // **********
    // main sequence
    // **********
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        wr(8'h20, 16'hFFFF);
        rd(`RSF_REG_CFG);
        chk(v, `RSF_CFG_RST);
        rd(`RSF_REG_TIMEOUT);
        chk(v, `RSF_TIMEOUT_RST);
        rd(8'h20);
        chk(v, 16'h0000);
        // every baud class, stalled reply at 9600
        for (int b = 0; b < 4; b++) begin
            mm.slow = (b == 1);
            wr(`RSF_REG_CFG, {8'h01, 6'h00, 2'(b)});
            frame(48'h014170000001, 16'h0801, 16'h0001, 64'h014170000001E6C5, 8);
        end
        wr(`RSF_REG_CFG, 16'h0101);
        frame(48'h014170000007, 16'h0801, 16'h0400, 64'h01C1047053, 5);
        wr(`RSF_REG_DELAY, 16'h000A);
        frame(48'h014170000001, 16'h0801, 16'h0001, 64'h014170000001E6C5, 8);
        chk({15'h0000, lat >= 8 * TICK}, 16'h0001);
        drop(48'h024170000001, -1);
        drop(48'h014170000001, 1);
        rd(`RSF_REG_STATUS);
        chk(v & 16'h0008, 16'h0008);
        wr(`RSF_REG_STATUS, 16'h0008);
        rd(`RSF_REG_STATUS);
        chk(v & 16'h0008, 16'h0000);
        wr(`RSF_REG_TIMEOUT, 16'h0004);
        frame(48'h004170000001, 16'h0803, 16'h0001, 64'h0, 0);
        chk({15'h0000, linkTimeout}, 16'h0001);
        wr(`RSF_REG_TIMEOUT, 16'h00FF);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0000, linkTimeout}, 16'h0000);
        wr(`RSF_REG_TIMEOUT, 16'h0004);
        wr(`RSF_REG_TIMEOUT, 16'h0000);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0000, linkTimeout}, 16'h0000);
        finish_test();
    end
endmodule : rsf_frame_timing_test
